// ==== bench/host_bus_model.sv ====
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input  wire logic        mclk,
  // register port
  output logic      [2:0]  regAddr,
  output logic             regRead,
  output logic             regWrite,
  output logic      [1:0]  regByteEn,
  output logic      [15:0] regWdata,
  input  wire logic [15:0] regRdata
);
  // ==========================================
  // idle bus at time zero
  initial begin
    regAddr   = 3'h0;
    regRead   = 1'h0;
    regWrite  = 1'h0;
    regByteEn = 2'h3;
    regWdata  = 16'h0000;
  end

  // ==========================================
  // word-wide write, one-cycle strobe
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr   <= a;
    regWdata  <= d;
    regByteEn <= 2'h3;
    regWrite  <= 1'h1;
    @(posedge mclk);
    regWrite  <= 1'h0;
    regWdata  <= ~d; // released data does not hold
  endtask

  // every read strobes regRead, so a receive_buffer read while a character is valid is a real pop, never a probe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge mclk);
    regRead <= 1'h0;
    #1 d = regRdata;
  endtask
endmodule

// ==== bench/test_mux_serial_csr_rx_silo.sv ====
`timescale 1ns/1ps
module test_mux_serial_csr_rx_silo;
  localparam int DEPTH = 16;
  logic        mclk, reset_n, busInit, regRead, regWrite, paramWrite, txLoad, rxStrobe;
  logic        rxParityFault, rxStopFault, rxOverrun, uartReset, scanActive;
  logic        receiveIrq, transmitIrq;
  logic [1:0]  regByteEn, rxCharLen;
  logic [2:0]  regAddr, rxLine;
  logic [7:0]  lineTxEnable, txBufEmpty, rxChar, txSerial, rxSerialPin, rxSerialUart;
  logic [15:0] regWdata, regRdata, paramData, rv;
  logic [31:0] seed, r;
  logic [15:0] exq[$];
  int          n_errors, n_checks, i;

  // clock
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  host_bus_model u_host (.mclk(mclk), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regByteEn(regByteEn), .regWdata(regWdata), .regRdata(regRdata));

  mux_serial_csr_rx_silo #(.SILO_DEPTH(DEPTH)) u_dut (.mclk(mclk), .reset_n(reset_n),
    .busInit(busInit), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regByteEn(regByteEn), .regWdata(regWdata), .regRdata(regRdata),
    .paramWrite(paramWrite), .paramData(paramData), .lineTxEnable(lineTxEnable),
    .txBufEmpty(txBufEmpty), .txLoad(txLoad), .rxStrobe(rxStrobe), .rxLine(rxLine),
    .rxChar(rxChar), .rxCharLen(rxCharLen), .rxParityFault(rxParityFault),
    .rxStopFault(rxStopFault), .rxOverrun(rxOverrun), .txSerial(txSerial),
    .rxSerialPin(rxSerialPin), .rxSerialUart(rxSerialUart), .uartReset(uartReset),
    .scanActive(scanActive), .receiveIrq(receiveIrq), .transmitIrq(transmitIrq));

  // ==========================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected buffer word: valid, flags, line, masked char
  function automatic logic [15:0] rxbuf_exp(logic [2:0] ln, logic [7:0] ch, logic [1:0] len,
                                            logic [2:0] fl);
    logic [7:0] mask;
    mask = 8'hFF >> (2'h3 - len);
    return {1'h1, fl, 1'h0, ln, ch & mask};
  endfunction

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic csr_is(input string nm, input logic [15:0] e);
    u_host.rd(3'h0, rv);
    check(nm, e, rv);
  endtask

  // bounded poll of one control_status bit
  task automatic wait_csr(input int b, input logic v, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      u_host.rd(3'h0, rv);
      if (rv[b] === v) break;
    end
    if (k == lim) begin
      n_errors++;
      $display("MISMATCH poll bit %0d expected %h seen %h", b, v, rv[b]);
      end_of_test();
    end
  endtask

  // offer one random character, record its expected word
  task automatic push(input logic ovr);
    logic [31:0] q;
    q = xs();
    @(posedge mclk);
    rxStrobe      <= 1'h1;
    rxLine        <= q[2:0];
    rxChar        <= q[10:3];
    rxCharLen     <= q[12:11];
    rxParityFault <= q[13];
    rxStopFault   <= q[14];
    rxOverrun     <= q[15];
    exq.push_back(rxbuf_exp(q[2:0], q[10:3], q[12:11], {ovr | q[15], q[14], q[13]}));
    @(posedge mclk);
    rxStrobe <= 1'h0;
    rxChar   <= ~q[10:3];
  endtask

  task automatic drain();
    while (exq.size() > 0) begin
      u_host.rd(3'h2, rv);
      check("receive_buffer", exq.pop_front(), rv);
    end
    u_host.rd(3'h2, rv);
    check("valid empty", 16'h0000, {rv[15], 15'h0000});
  endtask

  // ==========================================
  // main sequence
  initial begin
    seed = 32'h70A3C8EB;
    n_errors = 0;
    n_checks = 0;
    reset_n = 1'h0;
    {busInit, txLoad, rxStrobe, rxParityFault, rxStopFault, rxOverrun} = 6'h00;
    {rxLine, rxChar, rxCharLen, txSerial, rxSerialPin} = 29'h0;
    lineTxEnable = 8'h00;
    txBufEmpty = 8'hFF;
    repeat (12) @(posedge mclk);
    reset_n <= 1'h1;
    csr_is("csr reset", 16'h0000);
    u_host.rd(3'h4, rv);
    check("unmapped", 16'h0000, rv);
    u_host.wr(3'h0, 16'hFFEF);
    csr_is("csr rw bits", 16'h5068);
    r = xs();
    @(posedge mclk);
    {txSerial, rxSerialPin} <= r[15:0];
    @(posedge mclk);
    #1 check("loopback", {8'h00, txSerial}, {8'h00, rxSerialUart});
    done("registers");
    u_host.wr(3'h0, 16'h0068);
    push(1'h0);
    repeat (2) @(posedge mclk);
    #1 check("irq rx", 16'h0001, {15'h0000, receiveIrq});
    csr_is("char avail", 16'h00E8);
    for (i = 0; i < 5; i++) push(1'h0);
    drain();
    csr_is("csr drained", 16'h0068);
    done("receive");
    u_host.wr(3'h0, 16'h1068);
    for (i = 0; i < 15; i++) push(1'h0);
    csr_is("alarm at 15", 16'h10E8);
    check("irq masked", 16'h0000, {15'h0000, receiveIrq});
    push(1'h0);
    csr_is("alarm at 16", 16'h30E8);
    check("irq alarm", 16'h0001, {15'h0000, receiveIrq});
    push(1'h0);
    void'(exq.pop_back());
    u_host.rd(3'h2, rv);
    check("first entry", exq.pop_front(), rv);
    csr_is("alarm cleared", 16'h10E8);
    push(1'h1);
    drain();
    done("silo");
    u_host.wr(3'h0, 16'h4020);
    r = xs();
    txBufEmpty <= r[7:0] | 8'h20;
    lineTxEnable <= 8'h20;
    wait_csr(15, 1'h1, 20);
    check("ready line", 16'h0005, {13'h0000, rv[10:8]});
    check("irq tx", 16'h0001, {15'h0000, transmitIrq});
    @(posedge mclk);
    txLoad <= 1'h1;
    @(posedge mclk);
    txLoad <= 1'h0;
    repeat (300) @(posedge mclk);
    u_host.rd(3'h0, rv);
    check("holdoff", 16'h4020, rv & 16'hF8FF);
    check("irq tx off", 16'h0000, {15'h0000, transmitIrq});
    wait_csr(15, 1'h1, 150);
    check("ready again", 16'h0005, {13'h0000, rv[10:8]});
    done("transmit");
    @(posedge mclk);
    lineTxEnable <= 8'h00;
    push(1'h0);
    u_host.wr(3'h0, 16'h0038);
    csr_is("clear running", 16'h0010);
    check("uart reset", 16'h0001, {15'h0000, uartReset});
    wait_csr(4, 1'h0, 1700);
    check("csr cleared", 16'h0000, rv);
    check("loop off", {8'h00, rxSerialPin}, {8'h00, rxSerialUart});
    u_host.rd(3'h2, rv);
    check("valid cleared", 16'h0000, {rv[15], 15'h0000});
    check("data kept", exq[0] & 16'h7FFF, rv & 16'h7FFF);
    exq.delete();
    push(1'h0);
    u_host.rd(3'h2, rv);
    check("scan off", 16'h0000, {rv[15], 15'h0000});
    exq.delete();
    done("clear");
    u_host.wr(3'h0, 16'h5068);
    csr_is("csr set", 16'h5068);
    check("scan on", 16'h0001, {15'h0000, scanActive});
    push(1'h0);
    @(posedge mclk);
    busInit <= 1'h1;
    @(posedge mclk);
    busInit <= 1'h0;
    csr_is("csr after init", 16'h0000);
    u_host.rd(3'h2, rv);
    check("valid after init", 16'h0000, {rv[15], 15'h0000});
    exq.delete();
    r = xs();
    u_host.wr(3'h2, r[15:0]);
    #1 check("param strobe", 16'h0001, {15'h0000, paramWrite});
    check("param data", r[15:0], paramData);
    csr_is("csr untouched", 16'h0000);
    done("bus init");
    end_of_test();
  end
endmodule

// ==== logic/mux_serial_csr_rx_silo.sv ====
`timescale 1ns/1ps
module mux_serial_csr_rx_silo #(
  parameter int SILO_DEPTH = 64
) (
  // clock and resets
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        busInit,
  // register port
  input  wire logic [2:0]  regAddr,
  input  wire logic        regRead,
  input  wire logic        regWrite,
  input  wire logic [1:0]  regByteEn,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  // line parameter write-through
  output logic             paramWrite,
  output logic      [15:0] paramData,
  // transmit side
  input  wire logic [7:0]  lineTxEnable,
  input  wire logic [7:0]  txBufEmpty,
  input  wire logic        txLoad,
  // receive side
  input  wire logic        rxStrobe,
  input  wire logic [2:0]  rxLine,
  input  wire logic [7:0]  rxChar,
  input  wire logic [1:0]  rxCharLen,
  input  wire logic        rxParityFault,
  input  wire logic        rxStopFault,
  input  wire logic        rxOverrun,
  // serial loopback
  input  wire logic [7:0]  txSerial,
  input  wire logic [7:0]  rxSerialPin,
  output logic      [7:0]  rxSerialUart,
  // status
  output logic             uartReset,
  output logic             scanActive,
  output logic             receiveIrq,
  output logic             transmitIrq
);

  localparam int AW = $clog2(SILO_DEPTH);

  // ==========================================================
  // control state
  logic                          loopback;
  logic                          scanEnable;
  logic                          rxIrqEn;
  logic                          alarmEn;
  logic                          txIrqEn;
  logic                          clearing;
  logic [11:0]                   clrCnt;
  logic                          resetActive;
  logic                          csrWrite;
  logic                          bufRead;
  logic                          bufWrite;
  mux_serial_pkg::scan_state_t   scanState;
  logic [2:0]                    scanLine;
  logic [2:0]                    txLine;
  logic [8:0]                    holdCnt;
  logic                          txReady;
  logic [AW-1:0]                 wrPtr;
  logic [AW-1:0]                 rdPtr;
  logic [AW-1:0]                 next_rdPtr;
  logic [AW:0]                   count;
  logic                          stale;
  logic                          dropPending;
  logic                          push;
  logic                          pop;
  logic                          flush;
  logic                          rxDone;
  logic                          alarm;
  logic [4:0]                    alarmCnt;
  logic [7:0]                    charMask;
  logic [13:0]                   entryIn;
  logic [13:0]                   entryOut;

  // decode of the register port
  assign csrWrite  = regWrite && (regAddr == mux_serial_pkg::CSR_OFFSET);
  assign bufRead   = regRead && (regAddr == mux_serial_pkg::RXBUF_OFFSET);  // [RQ14]
  assign bufWrite  = regWrite && (regAddr == mux_serial_pkg::RXBUF_OFFSET); // [RQ14]

  // internal reset covers bus init and the one-shot
  assign resetActive = busInit || clearing; // [RQ2]
  assign uartReset   = resetActive;
  assign scanActive  = scanEnable;

  // ==========================================================
  // one-shot clear timer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clrCnt <= 12'h000;
    end else if (busInit) begin
      clrCnt <= 12'h000;
    end else if (csrWrite && regByteEn[0] && regWdata[mux_serial_pkg::CLEAR_BIT] && !clearing) begin
      clrCnt <= 12'(mux_serial_pkg::CLEAR_CYCLES); // [RQ2]
    end else if (clearing) begin
      clrCnt <= clrCnt - 12'h001;
    end
  end
  assign clearing = (clrCnt != 12'h000); // [RQ2]

  // writable control bits, cleared by either reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loopback   <= 1'b0;
      scanEnable <= 1'b0;
      rxIrqEn    <= 1'b0;
      alarmEn    <= 1'b0;
      txIrqEn    <= 1'b0;
    end else if (resetActive) begin
      loopback   <= 1'b0; // [RQ1]
      scanEnable <= 1'b0; // [RQ4]
      rxIrqEn    <= 1'b0;
      alarmEn    <= 1'b0; // [RQ12]
      txIrqEn    <= 1'b0;
    end else if (csrWrite) begin
      if (regByteEn[0]) begin
        loopback   <= regWdata[mux_serial_pkg::LOOP_BIT];
        scanEnable <= regWdata[mux_serial_pkg::SCAN_BIT]; // [RQ4]
        rxIrqEn    <= regWdata[mux_serial_pkg::RXIE_BIT];
      end
      if (regByteEn[1]) begin
        alarmEn <= regWdata[mux_serial_pkg::ALARMEN_BIT];
        txIrqEn <= regWdata[mux_serial_pkg::TXIE_BIT]; // [RQ11]
      end
    end
  end

  // serial turnaround for all lines
  assign rxSerialUart = loopback ? txSerial : rxSerialPin; // [RQ1]

  // ==========================================================
  // transmit scanner
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scanState <= mux_serial_pkg::SCAN_SEARCH;
      scanLine  <= 3'h0;
      txLine    <= 3'h0;
      holdCnt   <= 9'h000;
    end else if (resetActive) begin
      scanState <= mux_serial_pkg::SCAN_SEARCH; // [RQ8]
      scanLine  <= 3'h0;
      txLine    <= 3'h0; // [RQ10]
      holdCnt   <= 9'h000;
    end else if (!scanEnable) begin
      scanState <= mux_serial_pkg::SCAN_SEARCH;
    end else begin
      unique case (scanState)
        mux_serial_pkg::SCAN_SEARCH: begin
          if (txBufEmpty[scanLine] && lineTxEnable[scanLine]) begin
            txLine    <= scanLine; // [RQ7]
            scanState <= mux_serial_pkg::SCAN_READY;
          end else begin
            scanLine <= scanLine + 3'h1;
          end
        end
        mux_serial_pkg::SCAN_READY: begin
          if (txLoad) begin
            scanState <= mux_serial_pkg::SCAN_HOLD; // [RQ8]
            holdCnt   <= 9'(mux_serial_pkg::HOLDOFF_CYCLES - 1); // [RQ9]
            scanLine  <= txLine + 3'h1;
          end
        end
        mux_serial_pkg::SCAN_HOLD: begin
          if (holdCnt == 9'h000) begin
            scanState <= mux_serial_pkg::SCAN_SEARCH;
          end else begin
            holdCnt <= holdCnt - 9'h001;
          end
        end
      endcase
    end
  end
  assign txReady = (scanState == mux_serial_pkg::SCAN_READY); // [RQ7]

  // ==========================================================
  // receive silo control
  assign flush    = resetActive || !scanEnable; // [RQ16] [RQ17]
  assign rxDone   = (count != '0) && !stale; // [RQ6] [RQ22]
  assign push     = rxStrobe && !flush && (count != (AW+1)'(SILO_DEPTH)); // [RQ24]
  assign pop      = bufRead && rxDone && !flush; // [RQ15]
  assign charMask = 8'hFF >> (2'd3 - rxCharLen); // [RQ18]
  assign entryIn  = {rxOverrun || dropPending, rxStopFault, rxParityFault, rxLine,
                     rxChar & charMask}; // [RQ19] [RQ20] [RQ21]

  // next head address lets the memory present the new head at once
  always_comb begin
    if (pop) begin
      next_rdPtr = AW'(rdPtr + 1'b1); // [RQ15]
    end else begin
      next_rdPtr = rdPtr;
    end
  end

  // pointers, fill count and head settling
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      stale <= 1'b0;
    end else begin
      rdPtr <= next_rdPtr;
      stale <= push && (wrPtr == next_rdPtr); // [RQ6]
      if (flush) begin
        wrPtr <= rdPtr; // [RQ3] [RQ16] [RQ17]
        count <= '0;
      end else begin
        if (push) begin
          wrPtr <= AW'(wrPtr + 1'b1);
        end
        count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

  // a character dropped on a full silo marks the next stored one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dropPending <= 1'b0;
    end else if (flush || push) begin
      dropPending <= 1'b0;
    end else if (rxStrobe) begin
      dropPending <= 1'b1; // [RQ21]
    end
  end

  // storage, read data not reset so data bits survive a clear
  rx_silo_mem #(
    .WIDTH  (mux_serial_pkg::ENTRY_WIDTH),
    .DEPTH  (SILO_DEPTH),
    .AW     (AW)
  ) u_silo (
    .mclk   (mclk),
    .wrEn   (push),
    .wrAddr (wrPtr),
    .wrData (entryIn),
    .rdAddr (next_rdPtr),
    .rdData (entryOut) // [RQ3]
  );

  // ==========================================================
  // silo alarm
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alarm    <= 1'b0;
      alarmCnt <= 5'h00;
    end else if (flush) begin
      alarm    <= 1'b0;
      alarmCnt <= 5'h00;
    end else if (bufRead) begin
      alarm    <= 1'b0; // [RQ13]
      alarmCnt <= push ? 5'h01 : 5'h00;
    end else if (push && !alarm) begin
      if (alarmCnt == 5'(mux_serial_pkg::ALARM_COUNT - 1)) begin
        alarm    <= 1'b1; // [RQ13]
        alarmCnt <= 5'h00;
      end else begin
        alarmCnt <= alarmCnt + 5'h01;
      end
    end
  end

  // interrupt requests
  assign receiveIrq  = rxIrqEn && (alarmEn ? alarm : rxDone); // [RQ5] [RQ12]
  assign transmitIrq = txIrqEn && txReady; // [RQ11]

  // ==========================================================
  // register read data, answered one cycle after the read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      if (regAddr == mux_serial_pkg::CSR_OFFSET) begin
        regRdata <= {txReady, txIrqEn, alarm, alarmEn, 1'b0,
                     txLine, rxDone, rxIrqEn, scanEnable, clearing,
                     loopback, 3'b000}; // [RQ9] [RQ23]
      end else if (regAddr == mux_serial_pkg::RXBUF_OFFSET) begin
        regRdata <= {rxDone, entryOut[13:11], 1'b0, entryOut[10:0]}; // [RQ22] [RQ23]
      end else begin
        regRdata <= 16'h0000; // [RQ23]
      end
    end
  end

  // line parameter write pass-through
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      paramWrite <= 1'b0;
      paramData  <= 16'h0000;
    end else begin
      paramWrite <= bufWrite; // [RQ14]
      if (bufWrite) begin
        paramData <= regWdata;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_clear_req;
    csrWrite && regByteEn[0] && regWdata[mux_serial_pkg::CLEAR_BIT] && !clearing && !busInit;
  endsequence

  sequence s_clear_end;
    clearing && (clrCnt == 12'h001);
  endsequence

  a_loop_route: assert property (loopback |-> rxSerialUart == txSerial) // [RQ1]
    else $error("loopback not routing tx to rx");
  a_clear_start: assert property (s_clear_req |=> clearing ##1 clearing) // [RQ2]
    else $error("clear one-shot did not start");
  a_clear_end: assert property (s_clear_end |=> !clearing) // [RQ2]
    else $error("clear one-shot did not end");
  a_clear_csr: assert property (clearing |=> !scanEnable && !loopback && !alarmEn) // [RQ4]
    else $error("control bits survived clear");
  a_rx_irq_mask: assert property (alarmEn && !alarm |-> !receiveIrq) // [RQ5]
    else $error("receive irq from char available under alarm enable");
  a_scan_off_empty: assert property (!scanEnable |=> count == '0 && !rxDone) // [RQ16]
    else $error("silo not held empty");
  a_tx_holdoff: assert property (txReady && txLoad |=> !txReady [*8]) // [RQ9]
    else $error("ready line appeared too soon");
  a_tx_irq: assert property (txIrqEn && txReady |-> transmitIrq) // [RQ11]
    else $error("transmit irq missing");
  a_alarm_read: assert property (bufRead |=> !alarm) // [RQ13]
    else $error("alarm not cleared by read");
  a_read_pops: assert property (pop && !push |=> count == $past(count) - 1'b1) // [RQ15]
    else $error("buffer read did not advance silo");
  a_init_valid: assert property (busInit |=> !rxDone && !txReady && txLine == 3'h0) // [RQ17]
    else $error("bus init left valid or ready");

endmodule

// ==== logic/mux_serial_pkg.sv ====
// Function
// [RQ1] loopback bit turns every line around
// [RQ2] clear bit runs 15 us internal reset
// [RQ3] clear spares modem and buffer data bits
// [RQ4] scan enable starts scanner, cleared by resets
// [RQ5] char available interrupts only without alarm enable
// [RQ6] char available clears on read, resets on next
// [RQ7] tx ready when enabled line buffer empty
// [RQ8] tx ready cleared by resets and buffer load
// [RQ9] ready line number, new after 1.9 us
// [RQ10] ready line number returns to zero on reset
// [RQ11] tx irq enable requests irq while ready
// [RQ12] alarm enable selects silo alarm as irq
// [RQ13] alarm after 16 entries, cleared by read
// [RQ14] shared address: read buffer, write parameters
// [RQ15] each buffer read advances the silo
// [RQ16] scan enable off holds silo empty
// [RQ17] resets empty silo and clear valid bit
// [RQ18] character in low byte, unused bits zero
// [RQ19] buffer carries line number of character
// [RQ20] parity, framing and overrun flags per character
// [RQ21] overrun marks the entry that was kept
// [RQ22] valid bit high while character valid
// [RQ23] read-only bits unwritable, unused read zero
// [RQ24] shared silo of at least 16 entries
package mux_serial_pkg;

  // ==========================================================
  // register offsets
  localparam logic [2:0] CSR_OFFSET  = 3'h0;
  localparam logic [2:0] RXBUF_OFFSET = 3'h2;

  // ==========================================================
  // control_status bit positions
  localparam int LOOP_BIT     = 3;
  localparam int CLEAR_BIT    = 4;
  localparam int SCAN_BIT     = 5;
  localparam int RXIE_BIT     = 6;
  localparam int RXDONE_BIT   = 7;
  localparam int TXLINE_LSB   = 8;
  localparam int ALARMEN_BIT  = 12;
  localparam int ALARM_BIT    = 13;
  localparam int TXIE_BIT     = 14;
  localparam int TXRDY_BIT    = 15;

  // ==========================================================
  // receive_buffer field positions
  localparam int RLINE_LSB    = 8;
  localparam int PARITY_BIT   = 12;
  localparam int STOP_BIT     = 13;
  localparam int OVERRUN_BIT  = 14;
  localparam int VALID_BIT    = 15;

  // ==========================================================
  // reset values and sizes
  localparam logic [15:0] CSR_RESET   = 16'h0000;
  localparam int          LINE_COUNT  = 8;
  localparam int          ENTRY_WIDTH = 14;
  localparam int          ALARM_COUNT = 16;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int CLEAR_TIME_NS  = 15000;
  localparam int HOLDOFF_NS     = 1900;
  localparam int CLEAR_CYCLES   = (CLEAR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLDOFF_CYCLES = (HOLDOFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // transmit scanner states
  typedef enum logic [2:0] {
    SCAN_SEARCH = 3'b001,
    SCAN_READY  = 3'b010,
    SCAN_HOLD   = 3'b100
  } scan_state_t;

endpackage

// ==== logic/rx_silo_mem.sv ====
`timescale 1ns/1ps
module rx_silo_mem #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock
  input  wire logic             mclk,
  // write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read port
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write side
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // registered read data
  always_ff @(posedge mclk) begin
    rdData <= mem[rdAddr];
  end

endmodule
